// ===== logic/ir_fifo_port_and_event_regs.sv
// Purpose: Host data port, interrupt enable and event registers of the infrared controller.
// Assumes: Host strobes are synchronous to ref_clk; the line coder sits on the link ports.
// Notes: The other control registers live outside and arrive here as plain inputs.
`timescale 1ns/1ps
`default_nettype none
`include "ir_params.svh"

module ir_fifo_port_and_event_regs
    import ir_pkg::*;
#(
    parameter int DEPTH = `FIFO_DEPTH_DEFAULT,
    parameter int LEVEL_W = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Host parallel bus
    input wire logic cs_b,
    input wire logic rd_b,
    input wire logic wr_b,
    input wire logic [3:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // Interrupt
    output logic intr,
    // Settings held by the other control registers
    input wire ir_mode_t ir_mode,
    input wire logic tx_enable,
    input wire logic rx_enable,
    input wire logic fifo_clear_set,
    input wire logic [3:0] rx_threshold,
    input wire logic [3:0] tx_threshold,
    input wire logic [11:0] max_frame_size,
    output logic fifo_clear_bit,
    output logic [LEVEL_W-1:0] fifo_level,
    // Transmit shifter side
    output logic [7:0] tx_byte,
    output logic tx_valid,
    input wire logic tx_ready,
    input wire logic tx_shift_empty,
    // Receive shifter side
    input wire logic [7:0] rx_byte,
    input wire logic rx_byte_valid,
    input wire logic rx_byte_last,
    output logic rx_fifo_ready,
    input wire logic rx_framing_err,
    input wire logic rx_abort_seq,
    input wire logic rx_encode_err,
    input wire logic rx_crc_err,
    input wire logic rx_timeout
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    dir_t dir;
    logic rd_act;
    logic wr_act;
    logic rd_act_q;
    logic wr_act_q;
    logic rd_start;
    logic wr_start;
    logic [7:0] interrupt_enable;
    logic [7:0] event_flags;
    logic [7:0] set_ev;
    logic [7:0] clear_ev;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [8:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [8:0] fifo_out_data;
    logic host_pop;
    logic [11:0] frame_bytes;
    logic timeout_pending;
    logic frame_end_at_bottom;
    logic frame_end_at_bottom_q;
    logic tx_drained;
    logic tx_drained_q;
    logic rx_level_cond;
    logic tx_low_cond;
    logic line_err;
    logic sir_mode;

    // ----------------------------------------------------------------
    // Direction and host strobes
    // ----------------------------------------------------------------
    always_comb
    begin
        if (rx_enable)
        begin
            dir = DIR_RECV;
        end
        else if (tx_enable)
        begin
            dir = DIR_SEND;
        end
        else
        begin
            dir = DIR_IDLE;
        end
    end

    assign sir_mode = (ir_mode == MODE_SIR);
    assign rd_act = ~cs_b & ~rd_b;
    assign wr_act = ~cs_b & ~wr_b;
    // An access acts once, on the first cycle of its strobe.
    assign rd_start = rd_act & ~rd_act_q;
    assign wr_start = wr_act & ~wr_act_q;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
        end
        else
        begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
        end
    end

    // Only this block's three addresses are driven; the rest belong elsewhere.
    assign data_oe = rd_act && (addr == `ADDR_DATA_PORT || addr == `ADDR_INT_ENABLE ||
                                addr == `ADDR_EVENT_FLAGS);

    // ----------------------------------------------------------------
    // FIFO path
    // ----------------------------------------------------------------
    // receive-mode read pops
    assign host_pop = rd_start && addr == `ADDR_DATA_PORT && dir == DIR_RECV &&
                      fifo_out_valid;

    always_comb
    begin
        if (dir == DIR_RECV)
        begin
            fifo_in_valid = rx_byte_valid;
            fifo_in_data = {rx_byte_last, rx_byte};
            fifo_out_ready = host_pop;
        end
        else
        begin
            fifo_in_valid = wr_start && addr == `ADDR_DATA_PORT;
            fifo_in_data = {1'b0, data_in};
            fifo_out_ready = (dir == DIR_SEND) & tx_ready;
        end
    end

    assign rx_fifo_ready = (dir == DIR_RECV) & fifo_in_ready & ~fifo_clear_bit;
    assign tx_valid = (dir == DIR_SEND) & fifo_out_valid & ~fifo_clear_bit;
    assign tx_byte = fifo_out_data[7:0];

    ir_fifo #(
        .WIDTH(9),
        .DEPTH(DEPTH),
        .LEVEL_W(LEVEL_W)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .flush(fifo_clear_bit),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    // ----------------------------------------------------------------
    // FIFO clear
    // ----------------------------------------------------------------
    // The shifters are outside this block; a clear only holds off tx_valid and rx_fifo_ready to them.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fifo_clear_bit <= 1'b0;
        end
        else if (fifo_clear_set)
        begin
            fifo_clear_bit <= 1'b1;
        end
        else if (fifo_clear_bit && fifo_level == '0)
        begin
            fifo_clear_bit <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Register reads and writes
    // ----------------------------------------------------------------
    // enable register
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            interrupt_enable <= `INT_ENABLE_RESET;
        end
        else if (wr_start && addr == `ADDR_INT_ENABLE)
        begin
            interrupt_enable <= data_in;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            data_out <= `DATA_PORT_RESET;
        end
        else if (fifo_clear_bit)
        begin
            data_out <= `DATA_PORT_RESET;
        end
        else if (rd_start)
        begin
            unique case (addr)
                `ADDR_DATA_PORT: data_out <= host_pop ? fifo_out_data[7:0] : `DATA_PORT_RESET;
                `ADDR_INT_ENABLE: data_out <= interrupt_enable;
                `ADDR_EVENT_FLAGS: data_out <= event_flags;
                default: data_out <= `DATA_PORT_RESET;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Event sources
    // ----------------------------------------------------------------
    // mode-selected error
    always_comb
    begin
        unique case (ir_mode)
            MODE_SIR, MODE_EXT_SIR: line_err = rx_framing_err;
            MODE_MIR: line_err = rx_abort_seq;
            MODE_FIR: line_err = rx_encode_err;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            frame_bytes <= '0;
        end
        else if (dir != DIR_RECV || (rx_byte_valid && rx_byte_last))
        begin
            frame_bytes <= '0;
        end
        else if (rx_byte_valid && frame_bytes != 12'hFFF)
        begin
            frame_bytes <= frame_bytes + 12'h001;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            timeout_pending <= 1'b0;
        end
        else if (rx_timeout)
        begin
            timeout_pending <= 1'b1;
        end
        else if (host_pop)
        begin
            timeout_pending <= 1'b0;
        end
    end

    // Edge detectors keep read-cleared flags from re-arming on a standing level.
    assign frame_end_at_bottom = (dir == DIR_RECV) & fifo_out_valid & fifo_out_data[8];
    assign tx_drained = (dir == DIR_SEND) & ~fifo_out_valid & tx_shift_empty;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            frame_end_at_bottom_q <= 1'b0;
            tx_drained_q <= 1'b0;
        end
        else
        begin
            frame_end_at_bottom_q <= frame_end_at_bottom;
            tx_drained_q <= tx_drained;
        end
    end

    assign rx_level_cond = (fifo_level >= LEVEL_W'(rx_threshold)) | timeout_pending;
    assign tx_low_cond = (dir != DIR_RECV) & (fifo_level < LEVEL_W'(tx_threshold));

    // ----------------------------------------------------------------
    // Event register
    // ----------------------------------------------------------------
    // set regardless of enable
    always_comb
    begin
        set_ev = 8'h00;
        set_ev[`EV_LINE_ERR] = line_err;
        set_ev[`EV_OVERRUN] = (dir == DIR_RECV) & rx_byte_valid & ~rx_fifo_ready;
        set_ev[`EV_CRC_ERR] = rx_crc_err & ~sir_mode;
        set_ev[`EV_MAX_LEN] = (dir == DIR_RECV) & rx_byte_valid &
                              (frame_bytes == max_frame_size);
        set_ev[`EV_FRAME_END] = frame_end_at_bottom & ~frame_end_at_bottom_q & ~sir_mode;
        set_ev[`EV_RX_LEVEL] = rx_level_cond;
        set_ev[`EV_TX_LOW] = tx_low_cond;
        set_ev[`EV_TX_EMPTY] = tx_drained & ~tx_drained_q;
    end

    always_comb
    begin
        clear_ev = 8'h00;
        if (rd_start && addr == `ADDR_EVENT_FLAGS)
        begin
            clear_ev = `CLEAR_ON_READ_MASK;
        end
        clear_ev[`EV_RX_LEVEL] = ~rx_level_cond;
        clear_ev[`EV_TX_LOW] = ~tx_low_cond;
    end

    ir_event_sticky #(
        .WIDTH(8)
    ) u_events (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .set_ev(set_ev),
        .clear_ev(clear_ev),
        .flags(event_flags)
    );

    // ----------------------------------------------------------------
    // Interrupt
    // ----------------------------------------------------------------
    // enabled events OR
    assign intr = |(event_flags & interrupt_enable);
endmodule // ir_fifo_port_and_event_regs

`default_nettype wire

// ===== logic/ir_params.svh
// Purpose: Register offsets, field positions and reset values of the data port and event block.
// Assumes: Included by bare name from every file that needs it.
// Notes: Definitions only.
`ifndef IR_PARAMS_SVH
`define IR_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_DATA_PORT 4'h0
`define ADDR_INT_ENABLE 4'h1
`define ADDR_EVENT_FLAGS 4'h2

// ----------------------------------------------------------------
// Event and enable bit positions
// ----------------------------------------------------------------
`define EV_LINE_ERR 0
`define EV_OVERRUN 1
`define EV_CRC_ERR 2
`define EV_MAX_LEN 3
`define EV_FRAME_END 4
`define EV_RX_LEVEL 5
`define EV_TX_LOW 6
`define EV_TX_EMPTY 7

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define INT_ENABLE_RESET 8'h00
`define EVENT_FLAGS_RESET 8'h00
`define CLEAR_ON_READ_MASK 8'h9F
`define DATA_PORT_RESET 8'h00
`define FIFO_DEPTH_DEFAULT 8

`endif

// ===== logic/ir_pkg.sv
// Purpose: Types shared by the data port and event block.
// Assumes: Nothing.
// Notes: Constants live in ir_params.svh.
`default_nettype none

package ir_pkg;
    typedef enum logic [1:0] {MODE_SIR, MODE_EXT_SIR, MODE_MIR, MODE_FIR} ir_mode_t;
    typedef enum logic [1:0] {DIR_IDLE, DIR_SEND, DIR_RECV} dir_t;
endpackage

`default_nettype wire

// ===== logic/ir_fifo.sv
// Purpose: Shared transmit/receive FIFO with valid/ready on both sides.
// Assumes: Single clock; flush has priority over push and pop.
// Notes: Head word comes straight from the storage flops.
`timescale 1ns/1ps
`default_nettype none

module ir_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8,
    parameter int LEVEL_W = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [LEVEL_W-1:0] level
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic push;
    logic pop;

    assign in_ready = (level != LEVEL_W'(DEPTH));
    assign out_valid = (level != '0);
    assign push = in_valid & in_ready & ~flush;
    assign pop = out_valid & out_ready & ~flush;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end
        else if (flush)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop)
            begin
                level <= level + 1'b1;
            end
            else if (pop && !push)
            begin
                level <= level - 1'b1;
            end
        end
    end
endmodule // ir_fifo

`default_nettype wire

// ===== logic/ir_event_sticky.sv
// Purpose: Sticky event bits with per-bit set and clear.
// Assumes: Set and clear are one-cycle terms from the same clock.
// Notes: A set in the clearing cycle wins, so no event is lost.
`timescale 1ns/1ps
`default_nettype none
`include "ir_params.svh"

module ir_event_sticky #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Events
    input wire logic [WIDTH-1:0] set_ev,
    input wire logic [WIDTH-1:0] clear_ev,
    output logic [WIDTH-1:0] flags
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge ref_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    flags[i] <= 1'b0;
                end
                else if (set_ev[i])
                begin
                    flags[i] <= 1'b1;
                end
                else if (clear_ev[i])
                begin
                    flags[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule // ir_event_sticky

`default_nettype wire

// ===== tb/ir_port_assertions.sv
// Purpose: Port-level checks of the data port and event block.
// Assumes: One clock domain, reset active low.
// Notes: Bound to the top module below.
`timescale 1ns/1ps
`default_nettype none

module ir_port_checker #(
    parameter int DEPTH = 8,
    parameter int LEVEL_W = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Host bus
    input wire logic cs_b,
    input wire logic rd_b,
    input wire logic wr_b,
    input wire logic [3:0] addr,
    input wire logic data_oe,
    // Modes and FIFO
    input wire logic tx_enable,
    input wire logic rx_enable,
    input wire logic fifo_clear_set,
    input wire logic fifo_clear_bit,
    input wire logic [LEVEL_W-1:0] fifo_level,
    // Link sides
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic rx_byte_valid,
    input wire logic rx_fifo_ready
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic quiet;
    assign quiet = !fifo_clear_set && !fifo_clear_bit;
    sequence wr_data;
        !cs_b && !wr_b && $past(cs_b || wr_b) && addr == 4'h0;
    endsequence
    sequence rd_data;
        !cs_b && !rd_b && $past(cs_b || rd_b) && addr == 4'h0;
    endsequence
    sequence clear_walk;
        fifo_clear_bit ##1 fifo_level == 0 ##1 !fifo_clear_bit;
    endsequence
    chk_oe_decode: assert property (data_oe == (!cs_b && !rd_b && addr <= 4'h2))
        else $error("data bus enable decode wrong");
    chk_tx_gate: assert property (tx_valid |-> tx_enable && !rx_enable && fifo_level != 0)
        else $error("transmit valid outside send mode");
    chk_rx_gate: assert property (rx_fifo_ready == (rx_enable && fifo_level < DEPTH && !fifo_clear_bit))
        else $error("receive ready wrong");
    chk_clear_walk: assert property (fifo_clear_set && !fifo_clear_bit |=> clear_walk)
        else $error("clear sequence wrong");
    chk_push_count: assert property (wr_data ##0 (!rx_enable && fifo_level < DEPTH
        && quiet && !(tx_valid && tx_ready)) |=> fifo_level == $past(fifo_level) + 1'b1)
        else $error("write did not push");
    chk_pop_count: assert property (rd_data ##0 (rx_enable && fifo_level != 0
        && quiet && !rx_byte_valid) |=> fifo_level == $past(fifo_level) - 1'b1)
        else $error("read did not pop");
    chk_wrong_dir: assert property ((rd_data ##0 !rx_enable or wr_data ##0 rx_enable)
        ##0 (quiet && !(tx_valid && tx_ready) && !rx_byte_valid) |=> $stable(fifo_level))
        else $error("wrong direction access moved the FIFO");
    chk_overrun_drop: assert property (rx_byte_valid && !rx_fifo_ready && rx_enable
        && quiet && rd_b |=> $stable(fifo_level))
        else $error("byte entered a full FIFO");
endmodule // ir_port_checker

bind ir_fifo_port_and_event_regs ir_port_checker #(.DEPTH(DEPTH), .LEVEL_W(LEVEL_W)) chk_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b), .addr(addr),
    .data_oe(data_oe), .tx_enable(tx_enable), .rx_enable(rx_enable),
    .fifo_clear_set(fifo_clear_set), .fifo_clear_bit(fifo_clear_bit),
    .fifo_level(fifo_level), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_byte_valid(rx_byte_valid), .rx_fifo_ready(rx_fifo_ready));

`default_nettype wire

// ===== tb/host_model.sv
// Purpose: Host microcontroller on the 8-bit parallel bus.
// Assumes: Strobes move at the falling edge; one access per call.
// Notes: Released data lines show the inverse of the last byte.
`timescale 1ns/1ps
`default_nettype none

module host_model (
    // Clock
    input wire logic ref_clk,
    // Bus to the device
    output logic cs_b,
    output logic rd_b,
    output logic wr_b,
    output logic [3:0] addr,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out
);
    initial
    begin
        cs_b = 1'b1;
        rd_b = 1'b1;
        wr_b = 1'b1;
        addr = 4'h0;
        data_in = 8'h00;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        cs_b = 1'b0;
        wr_b = 1'b0;
        addr = a;
        data_in = d;
        @(negedge ref_clk);
        cs_b = 1'b1;
        wr_b = 1'b1;
        data_in = ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        cs_b = 1'b0;
        rd_b = 1'b0;
        addr = a;
        @(negedge ref_clk);
        d = data_out;
        cs_b = 1'b1;
        rd_b = 1'b1;
    endtask
endmodule // host_model

`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench of the data port and event block.
// Assumes: Inputs move at the falling edge of a 100 ns clock.
// Notes: Expected values come from the register map only.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic ref_clk, rst_b, cs_b, rd_b, wr_b, data_oe, intr, tx_enable, rx_enable;
    logic clr_set, clr_bit, tx_valid, tx_ready, tx_empty, rx_valid, rx_last, rx_ready;
    logic [3:0] addr, rx_th, tx_th, level;
    logic [7:0] data_in, data_out, tx_byte, rx_byte, rv;
    logic [11:0] max_size;
    logic [4:0] err;
    ir_pkg::ir_mode_t ir_mode;
    int fail_count, comparisons;

    host_model host (.ref_clk(ref_clk), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b), .addr(addr),
        .data_in(data_in), .data_out(data_out));
    ir_fifo_port_and_event_regs #(.DEPTH(8)) uut (.ref_clk(ref_clk), .rst_b(rst_b),
        .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .intr(intr), .ir_mode(ir_mode),
        .tx_enable(tx_enable), .rx_enable(rx_enable), .fifo_clear_set(clr_set),
        .rx_threshold(rx_th), .tx_threshold(tx_th), .max_frame_size(max_size),
        .fifo_clear_bit(clr_bit), .fifo_level(level), .tx_byte(tx_byte),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_shift_empty(tx_empty),
        .rx_byte(rx_byte), .rx_byte_valid(rx_valid), .rx_byte_last(rx_last),
        .rx_fifo_ready(rx_ready), .rx_framing_err(err[0]), .rx_abort_seq(err[1]),
        .rx_encode_err(err[2]), .rx_crc_err(err[3]), .rx_timeout(err[4]));

    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
            begin
                fail_count++;
                $display("BAD %0t got %h expected %h", $time, got, exp);
            end
    endtask
    task automatic ev(input logic [7:0] exp);
        host.rd(4'h2, rv);
        chk(rv, exp);
    endtask
    task automatic push(input logic [7:0] b, input logic last);
        @(negedge ref_clk);
        rx_byte = b;
        rx_valid = 1'b1;
        rx_last = last;
        @(negedge ref_clk);
        rx_valid = 1'b0;
        rx_last = 1'b0;
        rx_byte = ~b;
    endtask
    task automatic pulse(input int i);
        @(negedge ref_clk);
        err[i] = 1'b1;
        @(negedge ref_clk);
        err = 5'h00;
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // A hung handshake would stall the sequence, so a watchdog ends the run.
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial
    begin
        {rst_b, tx_enable, rx_enable, clr_set, tx_ready, rx_valid, rx_last} = 7'h00;
        {tx_empty, rx_th, tx_th, max_size, rx_byte, err} = {1'b1, 4'h4, 4'h2, 12'h003, 13'h0};
        ir_mode = ir_pkg::MODE_FIR;
        repeat (10) @(negedge ref_clk);
        rst_b = 1'b1;
        ev(8'h40);
        host.rd(4'h1, rv);
        chk(rv, 8'h00);
        host.wr(4'h1, 8'hA5);
        host.rd(4'h1, rv);
        chk(rv, 8'hA5);
        chk({7'h0, intr}, 8'h00);
        host.wr(4'h1, 8'h40);
        chk({7'h0, intr}, 8'h01);
        host.wr(4'h2, 8'hFF);
        host.rd(4'h5, rv);
        ev(8'h40);
        tx_enable = 1'b1;
        for (int i = 1; i < 4; i++) host.wr(4'h0, 8'(i * 17));
        ev(8'h80);
        ev(8'h00);
        host.rd(4'h0, rv);
        chk(rv, 8'h00);
        chk({4'h0, level}, 8'h03);
        tx_empty = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            chk({tx_valid, tx_byte[6:0]}, 8'(8'h80 + (i + 1) * 17));
            tx_ready = 1'b1;
            @(negedge ref_clk);
        end
        tx_ready = 1'b0;
        repeat (2) @(negedge ref_clk);
        ev(8'h40);
        tx_empty = 1'b1;
        repeat (2) @(negedge ref_clk);
        ev(8'hC0);
        tx_enable = 1'b0;
        tx_th = 4'h0;
        host.wr(4'h1, 8'h20);
        ev(8'h00);
        rx_enable = 1'b1;
        for (int i = 0; i < 5; i++) push(8'(8'hA0 + i), i == 4);
        chk({7'h0, intr}, 8'h01);
        ev(8'h28);
        max_size = 12'h010;
        for (int i = 0; i < 4; i++) push(8'(8'hB0 + i), 1'b0);
        ev(8'h22);
        host.wr(4'h0, 8'h77);
        chk({4'h0, level}, 8'h08);
        for (int i = 0; i < 8; i++)
        begin
            host.rd(4'h0, rv);
            chk(rv, 8'(i < 5 ? 8'hA0 + i : 8'hAB + i));
        end
        ev(8'h10);
        ev(8'h00);
        for (int m = 0; m < 4; m++)
        begin
            ir_mode = ir_pkg::ir_mode_t'(m);
            pulse(m < 2 ? 0 : m - 1);
            pulse(3);
            ev(m == 0 ? 8'h01 : 8'h05);
        end
        push(8'h5A, 1'b0);
        pulse(4);
        ev(8'h20);
        ev(8'h20);
        chk({7'h0, intr}, 8'h01);
        host.rd(4'h0, rv);
        chk(rv, 8'h5A);
        ev(8'h00);
        push(8'h01, 1'b0);
        push(8'h02, 1'b0);
        host.rd(4'h1, rv);
        chk(rv, 8'h20);
        clr_set = 1'b1;
        @(negedge ref_clk);
        clr_set = 1'b0;
        for (int i = 0; i < 8 && clr_bit !== 1'b0; i++) @(negedge ref_clk);
        chk({3'h0, clr_bit, level}, 8'h00);
        chk(data_out, 8'h00);
        host.rd(4'h0, rv);
        chk(rv, 8'h00);
        tally_and_finish();
    end
endmodule // tb_top

`default_nettype wire
